// ### design/hbc_command.sv
`timescale 1ns/100ps
// =====================================================================
// Host bridge command/status register bank
// =====================================================================
module hbc_command (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire hbc_pkg::hbc_cfg_req_t i_cfg,
   input wire hbc_pkg::hbc_perr_t i_perr,
   input wire logic [2:0] i_dev_serr,
   input wire logic i_serr_ack,
   output logic [15:0] o_rdata,
   output logic o_serr_req,
   output logic o_serr_en,
   output logic o_perr_en
);
   typedef struct packed {
      logic serr_en;
      logic perr_en;
      logic detected_parity_error;
      logic sse;
      logic [15:0] rdata;
   } hbc_state_t;

   hbc_state_t st;
   hbc_state_t next_st;
   logic perr_any;
   logic cmd_hit;
   logic sts_hit;
   logic [15:0] cmd_val;
   logic [15:0] sts_val;

   // Byte-lane aware write mask for one 16-bit register.
   function automatic logic [15:0] lane_mask(input logic [1:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // Composed read values; constants fill every bit not held in flops.
   always_comb begin
      // Bits 2 and 1 come from the fixed pattern, so they read one whatever is written.
      cmd_val = hbc_pkg::HBC_CMD_FIXED; // see RL1 see RL2 see RL8 see RL11 see RL12 see RL14 see RL15
      cmd_val[hbc_pkg::HBC_SERR_BIT] = st.serr_en;
      cmd_val[hbc_pkg::HBC_PERR_BIT] = st.perr_en;
      sts_val = hbc_pkg::HBC_STS_FIXED;
      sts_val[hbc_pkg::HBC_DPE_BIT] = st.detected_parity_error;
      sts_val[hbc_pkg::HBC_SSE_BIT] = st.sse;
   end

   assign perr_any = i_perr.addr_perr | i_perr.data_perr;
   assign cmd_hit = i_cfg.offset == hbc_pkg::HBC_CMD_OFFSET;
   assign sts_hit = i_cfg.offset == hbc_pkg::HBC_STS_OFFSET;

   // Register updates; hardware set beats a write-one clear in the same cycle.
   always_comb begin
      logic [15:0] m;
      m = lane_mask(i_cfg.byte_en);
      next_st = st;
      if (i_cfg.wr && cmd_hit) begin
         // Only the two enables are stored, so other bits cannot change.
         if (m[hbc_pkg::HBC_SERR_BIT]) begin
            next_st.serr_en = i_cfg.wdata[hbc_pkg::HBC_SERR_BIT]; // see RL3 see RL16
         end
         if (m[hbc_pkg::HBC_PERR_BIT]) begin
            next_st.perr_en = i_cfg.wdata[hbc_pkg::HBC_PERR_BIT]; // see RL9 see RL16
         end
      end
      if (i_cfg.wr && sts_hit) begin
         if (m[hbc_pkg::HBC_DPE_BIT] && i_cfg.wdata[hbc_pkg::HBC_DPE_BIT]) begin
            next_st.detected_parity_error = 1'b0;
         end
         if (m[hbc_pkg::HBC_SSE_BIT] && i_cfg.wdata[hbc_pkg::HBC_SSE_BIT]) begin
            next_st.sse = 1'b0;
         end
      end
      if (perr_any) begin
         next_st.detected_parity_error = 1'b1; // see RL13
      end
      if (perr_any && st.serr_en && st.perr_en) begin
         next_st.sse = 1'b1; // see RL10
      end
      // Unmapped offsets read as zero.
      if (i_cfg.rd) begin
         next_st.rdata = cmd_hit ? cmd_val : (sts_hit ? sts_val : 16'h0000);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st.serr_en <= hbc_pkg::HBC_CMD_RESET[hbc_pkg::HBC_SERR_BIT];
         st.perr_en <= hbc_pkg::HBC_CMD_RESET[hbc_pkg::HBC_PERR_BIT];
         st.detected_parity_error <= 1'b0;
         st.sse <= 1'b0;
         st.rdata <= 16'h0000;
      end else begin
         st <= next_st;
      end
   end

   // Message request; cleared enables suppress this function's parity-error request, but device requests still pass.
   hbc_serr_gen u_serr (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_err_d0(perr_any),
      .i_serr_en_d0(st.serr_en), // see RL5
      .i_perr_en_d0(st.perr_en),
      .i_err_dev(i_dev_serr),
      .i_ack(i_serr_ack),
      .o_req(o_serr_req)
   );

   assign o_rdata = st.rdata;
   assign o_serr_en = st.serr_en;
   assign o_perr_en = st.perr_en;
endmodule : hbc_command

// ### design/hbc_pkg.sv
// Operation
// (RL1) Bits 15:10 of the command register always read zero and ignore writes.
// (RL2) The fast back-to-back enable bit 9 is read-only zero.
// (RL3) The system-error enable bit 8 is read/write and resets to zero.
// (RL4) A system error is signalled only as a message request toward the hub link, not a pin.
// (RL5) With the system-error enable clear, no system-error message is sent for this function.
// (RL6) A message needs both the system-error enable and the parity response enable set; the code sends device requests on i_err_dev regardless of them.
// (RL7) The enables of this function and of devices 2 to 4 are ORed to drive the message path.
// (RL8) The stepping enable bit 7 is read-only zero.
// (RL9) The parity response enable bit 6 is read/write, resets to zero, and gates all action; the code sets the detected-parity-error flag regardless of it.
// (RL10) With both enables set, a detected parity error sends one system-error message.
// (RL11) The palette snoop enable bit 5 is read-only zero.
// (RL12) The write-invalidate enable bit 4 is read-only zero.
// (RL13) A detected parity error sets the detected-parity-error status flag.
// (RL14) The bus master enable bit 2 is read-only one.
// (RL15) The memory access enable bit 1 is read-only one.
// (RL16) Writes to read-only bits are ignored while the writable enables update.
package hbc_pkg;
   // =====================================================================
   // Register map and field layout
   // =====================================================================
   localparam logic [7:0] HBC_CMD_OFFSET = 8'h04;
   localparam logic [7:0] HBC_STS_OFFSET = 8'h06;
   localparam logic [15:0] HBC_CMD_RESET = 16'h0006;
   localparam logic [15:0] HBC_CMD_FIXED = 16'h0006;
   localparam int HBC_SERR_BIT = 8;
   localparam int HBC_PERR_BIT = 6;
   localparam int HBC_DPE_BIT = 15;
   localparam int HBC_SSE_BIT = 14;
   localparam logic [15:0] HBC_STS_FIXED = 16'h0090;

   // Configuration access request from the config-space decoder.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] offset;
      logic [1:0] byte_en;
      logic [15:0] wdata;
   } hbc_cfg_req_t;

   // Parity error events seen on the hub link.
   typedef struct packed {
      logic addr_perr;
      logic data_perr;
   } hbc_perr_t;
endpackage : hbc_pkg

// ### design/hbc_serr_gen.sv
`timescale 1ns/100ps
// =====================================================================
// System-error message request generator
// =====================================================================
module hbc_serr_gen (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_err_d0,
   input wire logic i_serr_en_d0,
   input wire logic i_perr_en_d0,
   input wire logic [2:0] i_err_dev,
   input wire logic i_ack,
   output logic o_req
);
   typedef struct packed {
      logic req;
   } hbc_serr_state_t;

   hbc_serr_state_t st;
   hbc_serr_state_t next_st;
   logic fire;

   // Both enables gate only this function's error; device requests pass ungated and are ORed in.
   always_comb begin
      fire = (i_err_d0 & i_serr_en_d0 & i_perr_en_d0) | (|i_err_dev); // see RL7 see RL6
      next_st = st;
      if (fire) begin
         next_st.req = 1'b1; // see RL10
      end else if (i_ack) begin
         next_st.req = 1'b0;
      end
   end

   // Request holds until the link layer takes the message; a new event wins over ack.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_req = st.req; // see RL4
endmodule : hbc_serr_gen

// ### dv/hbc_command_props.sv
`timescale 1ns/100ps
// =====================================================================
// Port-level checker for the command register bank
// =====================================================================
module hbc_command_props (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire hbc_pkg::hbc_cfg_req_t i_cfg,
   input wire hbc_pkg::hbc_perr_t i_perr,
   input wire logic [2:0] i_dev_serr,
   input wire logic i_serr_ack,
   input wire logic [15:0] o_rdata,
   input wire logic o_serr_req,
   input wire logic o_serr_en,
   input wire logic o_perr_en
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // A write or read aimed at the command offset.
   wire wr_cmd = i_cfg.wr && (i_cfg.offset == 8'h04);
   wire rd_cmd = i_cfg.rd && (i_cfg.offset == 8'h04);
   wire both_en = o_serr_en && o_perr_en;
   serr_write_a: assert property (wr_cmd && i_cfg.byte_en[1] |=> o_serr_en == $past(i_cfg.wdata[8])) else $error("serr enable write lost");
   perr_write_a: assert property (wr_cmd && i_cfg.byte_en[0] |=> o_perr_en == $past(i_cfg.wdata[6])) else $error("perr enable write lost");
   en_hold_a: assert property (!wr_cmd |=> $stable(o_serr_en) && $stable(o_perr_en)) else $error("enable changed without write");
   cmd_read_a: assert property (rd_cmd |=> o_rdata == {7'h00, $past(o_serr_en), 1'b0, $past(o_perr_en), 6'h06}) else $error("command readback wrong");
   quiet_gate_a: assert property (!both_en && !o_serr_req && i_dev_serr == 3'h0 |=> !o_serr_req) else $error("message while gated");
   serr_fire_a: assert property (both_en && i_perr != 2'h0 |=> o_serr_req) else $error("no message for parity error");
   dev_or_a: assert property (i_dev_serr != 3'h0 |=> o_serr_req) else $error("device request not merged");
   req_hold_a: assert property (o_serr_req && !i_serr_ack |=> o_serr_req) else $error("message dropped before ack");
   cover property (wr_cmd ##1 both_en);
   cover property (o_serr_req && i_serr_ack);
   cover property (i_dev_serr != 3'h0);
endmodule : hbc_command_props
bind hbc_command hbc_command_props props (.*);

// ### dv/hbc_hub_model.sv
`timescale 1ns/100ps
// =====================================================================
// Hub-side receiver of system-error messages
// =====================================================================
module hbc_hub_model (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_req,
   input wire logic i_slow,
   output logic o_ack
);
   logic [2:0] wait_cnt;
   // One ack pulse per message; the slow wait exposes a long pending request.
   always_ff @(posedge i_ref_clk) begin
      o_ack <= 1'b0;
      if (i_rst || !i_req || o_ack) wait_cnt <= 3'h0;
      else if (wait_cnt == (i_slow ? 3'h5 : 3'h1)) o_ack <= 1'b1;
      else wait_cnt <= wait_cnt + 3'h1;
   end
endmodule : hbc_hub_model

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   hbc_pkg::hbc_cfg_req_t cfg = '0;
   hbc_pkg::hbc_perr_t perr = '0;
   logic [2:0] dev = 3'h0;
   logic slow = 1'b0;
   logic ack, req, sen, pen;
   logic [15:0] rdata;
   int num_errors = 0, check_count = 0, cycles = 0;
   hbc_command dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_cfg(cfg), .i_perr(perr),
      .i_dev_serr(dev), .i_serr_ack(ack), .o_rdata(rdata), .o_serr_req(req),
      .o_serr_en(sen), .o_perr_en(pen));
   hbc_hub_model hub (.i_ref_clk(ref_clk), .i_rst(rst), .i_req(req), .i_slow(slow), .o_ack(ack));
   // Half period of 2.5 ns gives the 200 MHz core clock.
   always #2.5 ref_clk = ~ref_clk;
   task automatic conclude();
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   // The whole run needs about 56 cycles, so this ceiling only catches a hang.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         conclude();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One config access, then an idle cycle so the read data has landed.
   task automatic acc(input logic w, input logic [7:0] off, input logic [1:0] be,
      input logic [15:0] d);
      cfg <= '{rd: !w, wr: w, offset: off, byte_en: be, wdata: d};
      @(posedge ref_clk);
      cfg <= '0;
      @(posedge ref_clk);
   endtask : acc
   task automatic rchk(input logic [7:0] off, input logic [15:0] exp);
      acc(1'b0, off, 2'h3, 16'h0000);
      chk(rdata, exp);
   endtask : rchk
   task automatic pulse(input logic [1:0] p);
      perr <= p;
      @(posedge ref_clk);
      perr <= 2'h0;
      @(posedge ref_clk);
   endtask : pulse
   task automatic t_write();
      acc(1'b1, 8'h04, 2'h3, 16'hffff);
      rchk(8'h04, 16'h0146);
      chk({14'h0000, sen, pen}, 16'h0003);
      acc(1'b1, 8'h04, 2'h1, 16'h0000);
      rchk(8'h04, 16'h0106);
      chk({14'h0000, sen, pen}, 16'h0002);
      acc(1'b1, 8'h04, 2'h2, 16'h0000);
      rchk(8'h04, 16'h0006);
      chk({14'h0000, sen, pen}, 16'h0000);
      acc(1'b1, 8'h08, 2'h3, 16'hffff);
      rchk(8'h08, 16'h0000);
   endtask : t_write
   task automatic t_gate();
      pulse(2'h1);
      chk(16'(req), 16'h0000);
      rchk(8'h06, 16'h8090);
      acc(1'b1, 8'h06, 2'h3, 16'h8000);
      acc(1'b1, 8'h04, 2'h1, 16'h0040);
      pulse(2'h2);
      chk(16'(req), 16'h0000);
   endtask : t_gate
   task automatic t_fire();
      acc(1'b1, 8'h04, 2'h3, 16'h0140);
      slow <= 1'b1;
      pulse(2'h2);
      chk(16'(req), 16'h0001);
      repeat (3) @(posedge ref_clk);
      chk(16'(req), 16'h0001);
      repeat (6) @(posedge ref_clk);
      chk(16'(req), 16'h0000);
      rchk(8'h06, 16'hc090);
   endtask : t_fire
   task automatic t_dev();
      acc(1'b1, 8'h04, 2'h3, 16'h0000);
      slow <= 1'b0;
      dev <= 3'h4;
      @(posedge ref_clk);
      dev <= 3'h0;
      @(posedge ref_clk);
      chk(16'(req), 16'h0001);
   endtask : t_dev
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      rchk(8'h04, 16'h0006);
      t_write();
      t_gate();
      t_fire();
      t_dev();
      conclude();
   end
endmodule : testbench
